// [sras_pkg.sv]
// Package for the SPI register access slave: constants and carrier structs
package sras_pkg;
	localparam int SRAS_BYTE_W = 8; // Every link unit is one byte
	localparam int SRAS_ADDR_W = 8;
	localparam int SRAS_DEPTH = 256; // Register space reachable by the address byte
	localparam logic [2:0] SRAS_LAST_BIT = 3'h7;
	localparam int SRAS_RW_BIT = 7; // Read flag position in the command byte
	localparam logic [7:0] SRAS_REG_RESET = 8'h00;
	localparam int SRAS_CLK_MHZ = 50;
	localparam int SRAS_SCK_MAX_MHZ = 12;

	// Transaction phase
	typedef enum logic [1:0] {
		SRAS_CMD,
		SRAS_ADDR,
		SRAS_DATA
	} sras_phase_e;

	// Serial pins as seen by the block
	typedef struct packed {
		logic cs_n;
		logic sck;
		logic mosi;
	} sras_pins_in_s;

	typedef struct packed {
		logic miso;
		logic miso_oe;
	} sras_pins_out_s;

	// Register write strobe towards the device core
	typedef struct packed {
		logic wr_en;
		logic [7:0] addr;
		logic [7:0] data;
	} sras_wr_s;

	// Whole state of the serial engine
	typedef struct packed {
		logic [2:0] cs_sync;
		logic [2:0] sck_sync;
		logic [1:0] mosi_sync;
		sras_phase_e phase;
		logic [2:0] bit_cnt;
		logic [7:0] shift_in;
		logic [7:0] shift_out;
		logic read_mode;
		logic [7:0] addr_ptr;
		logic miso;
		logic miso_oe;
		sras_wr_s wr;
	} sras_state_s;
endpackage

// [sras_spi_slave.sv]
// SPI slave giving a host read and write access to a byte register space
// How it works
// - Four wires, device is slave, host master.
// - CS falling edge starts a new transaction.
// - MOSI sampled on SCK rising while selected.
// - Command, address and data are bytes.
// - Write pointer increments on eighth data edge.
// - Increment repeats for every further byte.
// - Every register reads back over link.
// - Command bit seven set means read.
// - Read data follows command and address.
// - Read pointer increments per returned byte.
`timescale 1ns/1ns
module sras_spi_slave
	import sras_pkg::*;
(
	input wire logic clock,
	input wire logic sys_rst,
	input wire sras_pkg::sras_pins_in_s pins_in,
	output sras_pkg::sras_pins_out_s pins_out,
	output sras_pkg::sras_wr_s wr_out,
	output logic [sras_pkg::SRAS_ADDR_W-1:0] reg_addr,
	output logic active
);
	import sras_pkg::*;

	// A 12 MHz SCK gives at least two 50 MHz samples per phase
	localparam int SRAS_MIN_SAMPLES = SRAS_CLK_MHZ / (2 * SRAS_SCK_MAX_MHZ);

	sras_state_s state_reg;
	sras_state_s state_next;
	logic [7:0] regs [0:SRAS_DEPTH-1];
	logic cs_n_s;
	logic cs_fall;
	logic sck_rise;
	logic sck_fall;
	logic mosi_s;
	logic [7:0] byte_in;
	logic [7:0] rd_data;
	logic [7:0] next_addr;

	// Synchronised pin views; stage 0 feeds only stage 1
	assign cs_n_s = state_reg.cs_sync[1];
	assign cs_fall = state_reg.cs_sync[2] & ~state_reg.cs_sync[1];
	assign sck_rise = ~state_reg.sck_sync[2] & state_reg.sck_sync[1];
	assign sck_fall = state_reg.sck_sync[2] & ~state_reg.sck_sync[1];
	assign mosi_s = state_reg.mosi_sync[1];
	assign byte_in = {state_reg.shift_in[6:0], mosi_s};
	assign next_addr = state_reg.addr_ptr + 8'h01;

	// Register read port; every location readable
	always_comb begin
		rd_data = regs[state_reg.addr_ptr];
	end

	// Next-state logic of the serial engine
	always_comb begin
		state_next = state_reg;
		state_next.cs_sync = {state_reg.cs_sync[1:0], pins_in.cs_n};
		state_next.sck_sync = {state_reg.sck_sync[1:0], pins_in.sck};
		state_next.mosi_sync = {state_reg.mosi_sync[0], pins_in.mosi};
		state_next.wr.wr_en = 1'b0;
		if (cs_n_s) begin
			// Deselected: drop partial byte, release MISO
			state_next.phase = SRAS_CMD;
			state_next.bit_cnt = 3'h0;
			state_next.miso_oe = 1'b0;
			state_next.miso = 1'b0;
			state_next.read_mode = 1'b0;
		end else begin
			if (cs_fall) begin
				state_next.phase = SRAS_CMD;
				state_next.bit_cnt = 3'h0;
				state_next.miso_oe = 1'b1;
				state_next.miso = 1'b0;
				state_next.shift_out = 8'h00;
			end else if (sck_rise) begin
				state_next.shift_in = byte_in;
				state_next.bit_cnt = state_reg.bit_cnt + 3'h1;
				if (state_reg.bit_cnt == SRAS_LAST_BIT) begin
					case (state_reg.phase)
						SRAS_CMD: begin
							state_next.read_mode = byte_in[SRAS_RW_BIT];
							state_next.phase = SRAS_ADDR;
						end
						SRAS_ADDR: begin
							state_next.addr_ptr = byte_in;
							state_next.phase = SRAS_DATA;
						end
						SRAS_DATA: begin
							if (!state_reg.read_mode) begin
								state_next.wr.wr_en = 1'b1;
								state_next.wr.addr = state_reg.addr_ptr;
								state_next.wr.data = byte_in;
							end
							state_next.addr_ptr = next_addr;
						end
						default: begin
							state_next.phase = SRAS_CMD;
						end
					endcase
				end
			end else if (sck_fall) begin
				// Shift MISO out on falling edges, MSB first
				if (state_reg.bit_cnt == 3'h0 && state_reg.phase == SRAS_DATA
					&& state_reg.read_mode) begin
					state_next.miso = rd_data[7];
					state_next.shift_out = {rd_data[6:0], 1'b0};
				end else begin
					state_next.miso = state_reg.shift_out[7];
					state_next.shift_out = {state_reg.shift_out[6:0], 1'b0};
				end
			end
		end
	end

	// State register
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			state_reg <= '{cs_sync: 3'h7, sck_sync: 3'h0, mosi_sync: 2'h0,
				phase: SRAS_CMD, bit_cnt: 3'h0, shift_in: 8'h00,
				shift_out: 8'h00, read_mode: 1'b0, addr_ptr: 8'h00,
				miso: 1'b0, miso_oe: 1'b0, wr: '0};
		end else begin
			state_reg <= state_next;
		end
	end

	// Register storage written by link writes
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			for (int i = 0; i < SRAS_DEPTH; i++) begin
				regs[i] <= SRAS_REG_RESET;
			end
		end else if (state_reg.wr.wr_en) begin
			regs[state_reg.wr.addr] <= state_reg.wr.data;
		end
	end

	// Outputs
	assign pins_out.miso = state_reg.miso;
	assign pins_out.miso_oe = state_reg.miso_oe;
	assign wr_out = state_reg.wr;
	assign reg_addr = state_reg.addr_ptr;
	assign active = ~cs_n_s;
endmodule

// [sras_chk.sv]
// Port checker for the SPI register access slave
`timescale 1ns/1ns
module sras_chk
	import sras_pkg::*;
(
	input wire logic clock,
	input wire logic sys_rst,
	input wire sras_pkg::sras_pins_in_s pins_in,
	input wire sras_pkg::sras_pins_out_s pins_out,
	input wire sras_pkg::sras_wr_s wr_out,
	input wire logic [7:0] reg_addr,
	input wire logic active
);
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	// Relations between pins and write strobe
	AST_CS_HIGH: assert property (pins_in.cs_n [*6] |-> !pins_out.miso_oe && !active)
		else $error("selected while idle");
	AST_CS_LOW: assert property ((!pins_in.cs_n && !sys_rst) [*6] |-> pins_out.miso_oe)
		else $error("not selected");
	AST_WR_ONE: assert property (wr_out.wr_en |=> !wr_out.wr_en)
		else $error("long strobe");
	AST_WR_INC: assert property (wr_out.wr_en |-> ##[0:2] reg_addr == wr_out.addr + 8'h01)
		else $error("no increment");
	AST_WR_DATA: assert property ($changed(wr_out.data) |-> wr_out.wr_en)
		else $error("data moved");
	AST_WR_SEL: assert property (wr_out.wr_en |-> active)
		else $error("write while idle");
	AST_MISO_HOLD: assert property ($rose(pins_in.sck) |=> $stable(pins_out.miso) [*3])
		else $error("miso moved");
	AST_ADDR_HOLD: assert property (!active [*4] |=> $stable(reg_addr))
		else $error("pointer moved");
	cover property (wr_out.wr_en);
	cover property (pins_out.miso_oe && pins_out.miso);
	cover property ($fell(active));
endmodule
bind sras_spi_slave sras_chk u_chk (.clock, .sys_rst, .pins_in, .pins_out, .wr_out, .reg_addr,
	.active);

// [sras_host.sv]
// Host model: SPI master in mode 0
`timescale 1ns/1ns
module sras_host
	import sras_pkg::*;
(
	input wire logic miso,
	input wire logic miso_oe,
	output sras_pkg::sras_pins_in_s pins
);
	logic line;
	// Released line shows a toggling pattern
	assign line = miso_oe ? miso : ~pins.sck;
	initial pins = 3'h4;
	task automatic start;
		pins.cs_n = 1'b0;
		#100;
	endtask
	task automatic stop;
		#80 pins.cs_n = 1'b1;
		#200;
	endtask
	// Shift n bits MSB first at 6.25 MHz
	task automatic xfer(input logic [7:0] d, input int n, output logic [7:0] q);
		for (int i = 7; i > 7 - n; i--) begin
			pins.mosi = d[i];
			#80 pins.sck = 1'b1;
			q[i] = line;
			#80 pins.sck = 1'b0;
		end
	endtask
endmodule

// [sras_tb_top.sv]
// Testbench of the SPI register access slave
`timescale 1ns/1ns
module sras_tb_top;
	import sras_pkg::*;
	logic clock = 0;
	logic sys_rst = 1;
	int err_count = 0;
	int tests_run = 0;
	logic [7:0] tx[$];
	logic [7:0] rx[$];
	logic [15:0] wq[$];
	logic [7:0] q;
	sras_pins_in_s pins;
	sras_pins_out_s po;
	sras_wr_s wr;
	sras_spi_slave uut (.clock(clock), .sys_rst(sys_rst), .pins_in(pins), .pins_out(po),
		.wr_out(wr), .reg_addr(), .active());
	sras_host host (.miso(po.miso), .miso_oe(po.miso_oe), .pins(pins));
	// Clock and write log
	initial forever #10 clock = ~clock;
	always @(posedge clock) if (wr.wr_en) wq.push_back({wr.addr, wr.data});
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %0t got %h want %h", $time, got, exp);
		end
	endtask
	// Whole frame: command, address, queued data
	task automatic frame(input logic [7:0] c, input logic [7:0] a);
		wq = {};
		rx = {};
		host.start();
		host.xfer(c, 8, q);
		host.xfer(a, 8, q);
		foreach (tx[i]) begin
			host.xfer(tx[i], 8, q);
			rx.push_back(q);
		end
		host.stop();
	endtask
	task automatic t_write;
		tx = '{8'h5a, 8'ha5, 8'h3c};
		frame(8'h00, 8'hfe);
		chk(8'(wq.size()), 8'h03);
		foreach (tx[i]) begin
			chk(wq[i][15:8], 8'hfe + 8'(i));
			chk(wq[i][7:0], tx[i]);
		end
		$display("write test done");
	endtask
	task automatic t_read;
		tx = '{8'h00, 8'h00};
		frame(8'h80, 8'hff);
		chk(rx[0], 8'ha5);
		chk(rx[1], 8'h3c);
		chk(8'(wq.size()), 8'h00);
		chk(8'(po.miso_oe), 8'h00);
		$display("read test done");
	endtask
	task automatic t_abort;
		host.start();
		host.xfer(8'hff, 5, q);
		host.stop();
		tx = '{8'hc3};
		frame(8'h00, 8'h10);
		chk(wq[0][15:8], 8'h10);
		frame(8'h80, 8'h10);
		chk(rx[0], 8'hc3);
		$display("abort test done");
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// Reset, then the scenarios
	initial begin
		repeat (2) @(posedge clock);
		#1 sys_rst = 0;
		@(posedge clock);
		#1;
		t_write();
		t_read();
		t_abort();
		results();
	end
	initial begin
		#300000;
		err_count++;
		results();
	end
endmodule
